// file: verification/ebwib_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
module ebwib_ext_model (
    // Clock and strobe from the controller
    input wire logic pclk,
    input wire logic ext_rd,
    // Separate read strobes seen
    output var int rd_n
);
    logic rd_q = 1'b0;
    // No reset pin: a memory only sees the bus, so it counts from power-up
    always @(posedge pclk) begin
        rd_q <= ext_rd;
        if (ext_rd && !rd_q) rd_n <= rd_n + 1;
    end
endmodule // ebwib_ext_model
`default_nettype wire

// file: verification/ebwib_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ebwib_top_sva (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Requests and strobes
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_ready,
    input wire logic ext_rd,
    input wire logic ext_wr,
    input wire logic cycle_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic take = req_valid && req_ready;
    chk_apb_ready: assert property (acc |-> pready) else $error("pready low");
    chk_err_phase: assert property (pslverr |-> acc) else $error("stray pslverr");
    chk_strobe_excl: assert property (!(ext_rd && ext_wr)) else $error("both strobes");
    chk_done_pulse: assert property (cycle_done |=> !cycle_done) else $error("long done");
    chk_done_bound: assert property (take |-> ##[3:40] cycle_done) else $error("no done");
    chk_busy_refuse: assert property (take |=> !req_ready [*2]) else $error("taken busy");
    chk_rd_strobe: assert property (take && !req_write |-> ##[1:6] ext_rd) else $error("no rd");
    chk_wr_strobe: assert property (take && req_write |-> ##[1:6] ext_wr) else $error("no wr");
    cov_read: cover property (take && !req_write);
    cov_write: cover property (take && req_write);
    cov_unmapped: cover property (acc && pslverr);
endmodule // ebwib_top_sva
bind ebwib_top ebwib_top_sva chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .req_valid, .req_write, .req_ready, .ext_rd, .ext_wr, .cycle_done);
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import ebwib_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, req_ready, ext_rd, ext_wr, cycle_done;
    logic req_valid = 1'b0, req_write = 1'b0;
    logic [1:0] req_area = 2'h0;
    logic [3:0] req_words = 4'h0;
    int bad_count = 0, checks = 0, cyc = 0, rd_n, t[8];
    ebwib_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .req_valid, .req_write, .req_area, .req_words, .req_ready,
        .ext_rd, .ext_wr, .cycle_done);
    ebwib_ext_model mem (.pclk, .ext_rd, .rd_n);
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic op(input logic w, input logic [1:0] a, input logic [3:0] n, input bit last);
        req_valid <= 1'b1;
        req_write <= w;
        req_area <= a;
        req_words <= n;
        do @(negedge pclk); while (req_ready !== 1'b1);
        @(posedge pclk);
        if (last) req_valid <= 1'b0;
    endtask
    // Two ops: accept to accept, so a pending idle state shows; one op: accept to done
    task automatic go(input logic w, input logic [1:0] a, input logic [3:0] n, input bit two,
        output int d);
        int c0;
        if (two) op(1'b0, 2'h0, 4'h1, 0);
        c0 = cyc;
        op(w, a, n, 1);
        if (!two) c0 = cyc;
        while (!two && cycle_done !== 1'b1) @(negedge pclk);
        d = cyc - c0;
        repeat (30) @(posedge pclk);
    endtask
    task automatic t_regs;
        apb(0, EBWIB_WAIT_OFS, 32'h0);
        chk("wait_reset", rd, 32'hFF);
        apb(0, EBWIB_CTRL_OFS, 32'h0);
        chk("ctrl_reset", rd, 32'hD0);
        apb(0, EBWIB_AST_OFS, 32'h0);
        chk("ast_reset", rd, 32'hF);
        apb(1, EBWIB_WAIT_OFS, 32'h1B);
        apb(0, EBWIB_WAIT_OFS, 32'h0);
        chk("wait_rw", rd, 32'h1B);
        apb(1, 12'h010, 32'hFF);
        chk("unmapped_err", err, 1);
        $display("test regs done");
    endtask
    task automatic t_wait;
        int b, d;
        apb(1, EBWIB_AST_OFS, 32'h0);
        go(0, 2'h1, 4'h1, 0, b);
        apb(1, EBWIB_AST_OFS, 32'hF);
        for (int i = 0; i < 4; i++) begin
            apb(1, EBWIB_WAIT_OFS, i << 2);
            go(0, 2'h1, 4'h1, 0, d);
            chk("wait_states", d - b, i + 1);
        end
        for (int g = 0; g < 4; g++) begin
            apb(1, EBWIB_WAIT_OFS, 32'h1 << (2 * g));
            go(0, g[1:0], 4'h1, 0, d);
            chk("area_wait", d - b, 2);
        end
        apb(1, EBWIB_WAIT_OFS, 32'hFF);
        apb(1, EBWIB_AST_OFS, 32'h0);
        go(0, 2'h1, 4'h1, 0, d);
        chk("two_state", d, b);
        $display("test waits done");
    endtask
    task automatic t_idle;
        int a0, w0, a, w, n0;
        for (int k = 0; k < 4; k++) begin
            apb(1, EBWIB_CTRL_OFS, k << 6);
            n0 = rd_n;
            go(0, 2'h1, 4'h1, 1, a);
            go(1, 2'h0, 4'h1, 1, w);
            if (k == 0) a0 = a;
            if (k == 0) w0 = w;
            chk("idle_rd_rd", a - a0, k[1]);
            chk("idle_rd_wr", w - w0, k[0]);
            if (k[1]) chk("rd_strobes", rd_n - n0, 3);
        end
        $display("test idle done");
    endtask
    task automatic t_burst;
        for (int k = 0; k < 8; k++) begin
            apb(1, EBWIB_CTRL_OFS, k << 3);
            go(0, 2'h0, 4'h8, 0, t[k]);
        end
        for (int k = 1; k < 4; k++) chk("basic_burst", t[k], t[0]);
        chk("burst_on", t[4] > t[0], 1);
        chk("limit_len1", t[5] - t[4], 4);
        chk("limit_len2", t[7] - t[6], 8);
        $display("test burst done");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_wait;
        t_idle;
        t_burst;
        give_verdict;
    end
    initial begin
        #400000;
        bad_count++;
        give_verdict;
    end
endmodule // tb
`default_nettype wire

// file: verilog/ebwib_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ebwib_cfg_if;
    logic [7:0] wait_cnt;
    logic [7:0] ctrl;
    logic [3:0] ast;
    modport regs (output wait_cnt, output ctrl, output ast);
    modport seq (input wait_cnt, input ctrl, input ast);
endinterface // ebwib_cfg_if
`default_nettype wire

// file: verilog/ebwib_pkg.sv
// Functional notes
// - Two-bit wait field per area 0..3
// - Field value gives zero to three waits
// - Waits apply only with three-state select
// - Idle cycle between reads to different areas
// - Idle cycle between read and following write
// - Bit 5 selects burst ROM for area 0
// - Bit 4 sets burst cycle one or two states
// - Bit 3 limits burst to four or eight words
// - Select zero two-state, one three-state with waits
`default_nettype none
package ebwib_pkg;
    localparam logic [11:0] EBWIB_WAIT_OFS = 12'h000;
    localparam logic [11:0] EBWIB_CTRL_OFS = 12'h004;
    localparam logic [11:0] EBWIB_AST_OFS = 12'h008;
    localparam logic [11:0] EBWIB_STAT_OFS = 12'h00C;
    localparam logic [7:0] EBWIB_WAIT_RST = 8'hFF;
    localparam logic [7:0] EBWIB_CTRL_RST = 8'hD0;
    localparam logic [3:0] EBWIB_AST_RST = 4'hF;
    localparam int EBWIB_IDLE_AREA_BIT = 7;
    localparam int EBWIB_IDLE_RW_BIT = 6;
    localparam int EBWIB_BURST_SEL_BIT = 5;
    localparam int EBWIB_BURST_LEN_BIT = 4;
    localparam int EBWIB_BURST_LIM_BIT = 3;
    localparam logic [3:0] EBWIB_BURST_4 = 4'h4;
    localparam logic [3:0] EBWIB_BURST_8 = 4'h8;
    typedef enum logic [2:0] {
        EBWIB_IDLE = 3'b000,
        EBWIB_T1 = 3'b001,
        EBWIB_T2 = 3'b011,
        EBWIB_TW = 3'b010,
        EBWIB_T3 = 3'b110,
        EBWIB_TB = 3'b111,
        EBWIB_TI = 3'b100
    } ebwib_state_t;
endpackage
`default_nettype wire

// file: verilog/ebwib_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ebwib_regs import ebwib_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status
    input wire logic [7:0] status,
    // Config
    ebwib_cfg_if.regs cfg
);
    logic [7:0] wait_q;
    logic [7:0] ctrl_q;
    logic [3:0] ast_q;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_wait = paddr == EBWIB_WAIT_OFS;
    wire hit_ctrl = paddr == EBWIB_CTRL_OFS;
    wire hit_ast = paddr == EBWIB_AST_OFS;
    wire hit_stat = paddr == EBWIB_STAT_OFS;
    wire mapped = hit_wait | hit_ctrl | hit_ast | hit_stat;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    // Reserved control bits are kept as written
    assign prdata = hit_wait ? {24'h000000, wait_q} :
                    hit_ctrl ? {24'h000000, ctrl_q} :
                    hit_ast ? {28'h0000000, ast_q} :
                    hit_stat ? {24'h000000, status} : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= EBWIB_WAIT_RST;
            ctrl_q <= EBWIB_CTRL_RST;
            ast_q <= EBWIB_AST_RST;
        end else begin
            if (wr && hit_wait) wait_q <= pwdata[7:0];
            if (wr && hit_ctrl) ctrl_q <= pwdata[7:0];
            if (wr && hit_ast) ast_q <= pwdata[3:0];
        end
    end
    assign cfg.wait_cnt = wait_q;
    assign cfg.ctrl = ctrl_q;
    assign cfg.ast = ast_q;
endmodule // ebwib_regs
`default_nettype wire

// file: verilog/ebwib_top.sv
`timescale 1ns/100ps
`default_nettype none
module ebwib_top import ebwib_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Internal access request, one bus state per pclk
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_area,
    input wire logic [3:0] req_words,
    output logic req_ready,
    // External strobes
    output logic ext_rd,
    output logic ext_wr,
    output logic cycle_done
);
    ebwib_cfg_if cfg_if ();
    ebwib_state_t st_q, st_d;
    logic [1:0] wcnt_q, wcnt_d;
    logic [3:0] words_q, words_d;
    logic bcyc_q, bcyc_d;
    logic wr_q, wr_d;
    logic [1:0] area_q, area_d;
    logic last_rd_q, last_rd_d;
    logic [1:0] last_area_q, last_area_d;
    logic rd_o_q, wr_o_q, done_q;
    logic [7:0] status;

    ebwib_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status(status),
        .cfg(cfg_if.regs)
    );

    // Per-area wait count, zeroed on two-state areas
    logic [1:0] waits [4];
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_area
            assign waits[g] = cfg_if.ast[g] ? cfg_if.wait_cnt[2*g+1:2*g] : 2'b00;
        end
    endgenerate

    wire burst_on = cfg_if.ctrl[EBWIB_BURST_SEL_BIT] && req_area == 2'h0 && !req_write;
    wire [3:0] burst_lim = cfg_if.ctrl[EBWIB_BURST_LIM_BIT] ? EBWIB_BURST_8 : EBWIB_BURST_4;
    wire [3:0] nwords = !burst_on ? 4'h1 :
                        req_words == 4'h0 ? 4'h1 :
                        req_words > burst_lim ? burst_lim : req_words;
    wire idle_area = cfg_if.ctrl[EBWIB_IDLE_AREA_BIT] && last_rd_q && !req_write
                     && req_area != last_area_q;
    wire idle_rw = cfg_if.ctrl[EBWIB_IDLE_RW_BIT] && last_rd_q && req_write;
    wire need_idle = idle_area | idle_rw;
    wire start = req_valid && (st_q == EBWIB_TI || (st_q == EBWIB_IDLE && !need_idle));
    wire cur_three = cfg_if.ast[area_q];
    wire [1:0] cur_wait = waits[area_q];

    assign req_ready = start;
    assign status = {st_q, last_rd_q, last_area_q, cfg_if.ctrl[EBWIB_BURST_SEL_BIT], 1'b0};

    always_comb begin
        st_d = st_q;
        wcnt_d = wcnt_q;
        words_d = words_q;
        bcyc_d = bcyc_q;
        wr_d = wr_q;
        area_d = area_q;
        last_rd_d = last_rd_q;
        last_area_d = last_area_q;
        case (st_q)
            EBWIB_IDLE: begin
                if (req_valid && need_idle) begin
                    st_d = EBWIB_TI;
                end else if (req_valid) begin
                    st_d = EBWIB_T1;
                    wr_d = req_write;
                    area_d = req_area;
                    words_d = nwords;
                    wcnt_d = 2'b00;
                end
            end
            EBWIB_TI: begin
                // One state, strobes idle; taking the request here keeps the gap to one state
                last_rd_d = 1'b0;
                if (req_valid) begin
                    st_d = EBWIB_T1;
                    wr_d = req_write;
                    area_d = req_area;
                    words_d = nwords;
                    wcnt_d = 2'b00;
                end else begin
                    st_d = EBWIB_IDLE;
                end
            end
            EBWIB_T1: st_d = EBWIB_T2;
            EBWIB_T2: begin
                if (!cur_three) begin
                    st_d = EBWIB_TB;
                end else if (cur_wait != 2'b00) begin
                    st_d = EBWIB_TW;
                    wcnt_d = 2'b01;
                end else begin
                    st_d = EBWIB_T3;
                end
            end
            EBWIB_TW: begin
                if (wcnt_q == cur_wait) begin
                    st_d = EBWIB_T3;
                end else begin
                    wcnt_d = wcnt_q + 2'b01;
                end
            end
            EBWIB_T3: begin
                st_d = EBWIB_TB;
            end
            EBWIB_TB: begin
                // Each further burst word costs one or two states
                if (words_q > 4'h1) begin
                    if (cfg_if.ctrl[EBWIB_BURST_LEN_BIT] && !bcyc_q) begin
                        bcyc_d = 1'b1;
                    end else begin
                        bcyc_d = 1'b0;
                        words_d = words_q - 4'h1;
                    end
                end else begin
                    st_d = EBWIB_IDLE;
                    last_rd_d = !wr_q;
                    last_area_d = area_q;
                end
            end
            default: st_d = EBWIB_IDLE;
        endcase
    end

    wire strobe = st_q != EBWIB_IDLE && st_q != EBWIB_TI && st_q != EBWIB_T1 ? 1'b1 : 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= EBWIB_IDLE;
            wcnt_q <= 2'b00;
            words_q <= 4'h0;
            bcyc_q <= 1'b0;
            wr_q <= 1'b0;
            area_q <= 2'b00;
            last_rd_q <= 1'b0;
            last_area_q <= 2'b00;
        end else begin
            st_q <= st_d;
            wcnt_q <= wcnt_d;
            words_q <= words_d;
            bcyc_q <= bcyc_d;
            wr_q <= wr_d;
            area_q <= area_d;
            last_rd_q <= last_rd_d;
            last_area_q <= last_area_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_o_q <= 1'b0;
            wr_o_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            rd_o_q <= strobe && !wr_q;
            wr_o_q <= strobe && wr_q;
            done_q <= st_q == EBWIB_TB && st_d == EBWIB_IDLE;
        end
    end

    assign ext_rd = rd_o_q;
    assign ext_wr = wr_o_q;
    assign cycle_done = done_q;
endmodule // ebwib_top
`default_nettype wire
